// ### dma_bus_cfg_pkg.sv
// Constants for the DMA bus configuration register bank.
// Assumes a 32-bit APB slave clocked by pclk at 125 MHz.

package dma_bus_cfg_pkg;

   // ----------------------------------------------------------------
   // Bus widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int CFG_W  = 16;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_DATA_CONFIG = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_CYCLE_STATUS = 12'h004;

   // ----------------------------------------------------------------
   // Field positions in data_configuration
   // ----------------------------------------------------------------
   localparam int USER_PIN_DRIVE_HI = 12;
   localparam int USER_PIN_DRIVE_LO = 11;
   localparam int SYNC_READY_BIT    = 10;
   localparam int USER_STRAP_HI     = 9;
   localparam int USER_STRAP_LO     = 8;
   localparam int WAIT_COUNT_HI     = 7;
   localparam int WAIT_COUNT_LO     = 6;
   localparam int DMA_WIDTH_BIT     = 5;

   // ----------------------------------------------------------------
   // Reset value and writable bits
   // ----------------------------------------------------------------
   localparam logic [CFG_W-1:0] CFG_RESET      = 16'h0000;
   localparam logic [CFG_W-1:0] CFG_WRITE_MASK = 16'h1CE0;

   // ----------------------------------------------------------------
   // Field positions in cycle_status
   // ----------------------------------------------------------------
   localparam int STAT_STATE_HI   = 1;
   localparam int STAT_STATE_LO   = 0;
   localparam int STAT_MASTER_BIT = 2;
   localparam int STAT_COUNT_LO   = 8;
   localparam int DONE_COUNT_W    = 8;

   // ----------------------------------------------------------------
   // Timing counts, in bus clocks
   // ----------------------------------------------------------------
   localparam logic [2:0] MIN_CYCLE_ASYNC = 3'h3;
   localparam logic [2:0] MIN_CYCLE_SYNC  = 3'h2;

   // ----------------------------------------------------------------
   // DMA cycle states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      st_idle,
      st_t1,
      st_t2
   } cycle_state_t;

endpackage

// ### ready_sync.sv
// Two-stage synchroniser for the ready input.
// First stage samples on the falling clock edge, second on the rising.

`timescale 1ns/100ps

module ready_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] fall_q;

   // ----------------------------------------------------------------
   // Falling edge stage
   // ----------------------------------------------------------------
   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
         fall_q <= '0;
      end else begin
         fall_q <= async_in;
      end
   end

   // ----------------------------------------------------------------
   // Rising edge stage
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_out <= '0;
      end else begin
         sync_out <= fall_q;
      end
   end

endmodule

// ### strap_capture.sv
// Captures strap pin levels once, at the first clock after reset release.
// Assumes the pins are not driven by this device while reset is held.

`timescale 1ns/100ps

module strap_capture #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Strap pins and held value
   input  wire logic [WIDTH-1:0] pins,
   output logic      [WIDTH-1:0] strap_q
);

   logic armed_q;

   // ----------------------------------------------------------------
   // One-shot capture, then hold until next reset
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b1;
         strap_q <= '0;
      end else if (armed_q) begin
         armed_q <= 1'b0;
         strap_q <= pins;
      end
   end

endmodule

// ### dma_bus_config_fields.sv
// DMA bus configuration fields with APB access and a DMA cycle timer.
// Assumes APB master on pclk and bus ready lines active high.
//
// The register addresses and register access over APB are this design's own decisions.

`timescale 1ns/100ps

module dma_bus_config_fields
   import dma_bus_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [DATA_W-1:0] pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Bus mastership and protocol
   input  wire logic              hold_acknowledge,
   input  wire logic              bus_grant_acknowledge,
   input  wire logic              bus_protocol_select,
   input  wire logic              dma_cycle_req,
   // Ready inputs
   input  wire logic              ready_in,
   input  wire logic [1:0]        data_size_acknowledge,
   // User pins
   input  wire logic [1:0]        user_strap_pins_in,
   output logic      [1:0]        user_pin_out,
   output logic      [1:0]        user_pin_oe,
   // DMA cycle status
   output logic                   dma_t1,
   output logic                   dma_t2,
   output logic                   dma_cycle_done,
   output logic                   dma_width_32
);

   // ----------------------------------------------------------------
   // Registers and next values
   // ----------------------------------------------------------------
   logic [CFG_W-1:0]        cfg_q;
   logic [CFG_W-1:0]        cfg_d;
   logic [1:0]              strap_q;
   logic [DATA_W-1:0]       prdata_q;
   logic                    pready_q;
   logic                    pslverr_q;
   cycle_state_t            state_q;
   cycle_state_t            state_d;
   logic [1:0]              waits_q;
   logic [1:0]              waits_d;
   logic [2:0]              cyc_q;
   logic [2:0]              cyc_d;
   logic                    ready_t1_q;
   logic                    ready_synced;
   logic [1:0]              user_pin_out_q;
   logic [1:0]              user_pin_oe_q;
   logic                    dma_t1_q;
   logic                    dma_t2_q;
   logic                    done_q;
   logic                    width_32_q;
   logic [DONE_COUNT_W-1:0] done_count_q;

   // ----------------------------------------------------------------
   // Decode and field wires
   // ----------------------------------------------------------------
   wire                    apb_access;
   wire                    apb_first;
   wire                    apb_ack;
   wire                    sel_cfg;
   wire                    sel_stat;
   wire                    mapped;
   wire                    cfg_wr;
   wire [CFG_W-1:0]        lane_mask;
   wire [CFG_W-1:0]        wr_mask;
   wire [CFG_W-1:0]        cfg_rd;
   wire [DATA_W-1:0]       stat_rd;
   wire [DATA_W-1:0]       rd_data;
   wire                    mastership;
   wire [1:0]              drive_bits;
   wire                    sync_ready_select;
   wire [1:0]              wait_state_count;
   wire                    dma_width_select;
   wire                    ready_raw;
   wire                    ready_ok;
   wire [2:0]              min_cycles;
   wire                    min_met;
   wire                    cycle_end;
   wire                    cycle_done;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign apb_access = psel & penable;
   assign apb_first  = apb_access & ~pready_q;
   assign apb_ack    = apb_access & pready_q;
   assign sel_cfg    = (paddr == ADDR_DATA_CONFIG);
   assign sel_stat   = (paddr == ADDR_CYCLE_STATUS);
   assign mapped     = sel_cfg | sel_stat;
   assign cfg_wr     = apb_ack & pwrite & sel_cfg;

   assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign wr_mask   = lane_mask & CFG_WRITE_MASK;
   assign cfg_d     = (cfg_q & ~wr_mask) | (pwdata[CFG_W-1:0] & wr_mask);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   assign cfg_rd = cfg_q | {6'h00, strap_q, 8'h00};

   assign stat_rd = {
      16'h0000,
      done_count_q,
      5'h00,
      mastership,
      state_q
   };

   assign rd_data = sel_cfg  ? {16'h0000, cfg_rd} :
                    sel_stat ? stat_rd :
                               32'h0000_0000;

   // ----------------------------------------------------------------
   // Configuration fields
   // ----------------------------------------------------------------
   assign drive_bits        = cfg_q[USER_PIN_DRIVE_HI:USER_PIN_DRIVE_LO];
   assign sync_ready_select = cfg_q[SYNC_READY_BIT];
   assign wait_state_count  = cfg_q[WAIT_COUNT_HI:WAIT_COUNT_LO];
   assign dma_width_select  = cfg_q[DMA_WIDTH_BIT];

   // ----------------------------------------------------------------
   // APB slave registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= apb_first;
         pslverr_q <= apb_first & ~mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (apb_first) begin
         prdata_q <= rd_data;
      end
   end

   // ----------------------------------------------------------------
   // Configuration register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= CFG_RESET;
      end else if (cfg_wr) begin
         cfg_q <= cfg_d;
      end
   end

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   strap_capture #(
      .WIDTH (2)
   ) u_strap (
      .pclk    (pclk),
      .presetn (presetn),
      .pins    (user_strap_pins_in),
      .strap_q (strap_q)
   );

   // ----------------------------------------------------------------
   // Bus mastership
   // ----------------------------------------------------------------
   assign mastership = hold_acknowledge | bus_grant_acknowledge;

   // ----------------------------------------------------------------
   // User pin drivers, one per pin
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_user_pin
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            user_pin_out_q[i] <= 1'b0;
            user_pin_oe_q[i]  <= 1'b0;
         end else begin
            user_pin_out_q[i] <= drive_bits[i];
            user_pin_oe_q[i]  <= mastership;
         end
      end
   end

   // ----------------------------------------------------------------
   // Ready selection
   // ----------------------------------------------------------------
   assign ready_raw = bus_protocol_select ? (|data_size_acknowledge)
                                          : ready_in;

   // ----------------------------------------------------------------
   // Falling edge synchroniser for asynchronous ready
   // ----------------------------------------------------------------
   ready_sync #(
      .WIDTH (1)
   ) u_ready_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (ready_raw),
      .sync_out (ready_synced)
   );

   assign ready_ok = sync_ready_select ? (ready_raw | ready_t1_q)
                                       : ready_synced;

   // ----------------------------------------------------------------
   // Cycle end conditions
   // ----------------------------------------------------------------
   assign min_cycles = sync_ready_select ? MIN_CYCLE_SYNC
                                         : MIN_CYCLE_ASYNC;
   assign min_met    = (cyc_q >= (min_cycles - 3'h1));
   assign cycle_end  = (state_q == st_t2) & (waits_q == 2'h0) &
                       min_met & ready_ok;
   assign cycle_done = cycle_end & mastership;

   // ----------------------------------------------------------------
   // DMA cycle sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      waits_d = waits_q;
      cyc_d   = cyc_q;
      unique case (state_q)
         st_idle: begin
            cyc_d = 3'h0;
            if (dma_cycle_req & mastership) begin
               state_d = st_t1;
            end
         end
         st_t1: begin
            state_d = st_t2;
            waits_d = wait_state_count;
            cyc_d   = 3'h1;
         end
         st_t2: begin
            if (cyc_q != 3'h7) begin
               cyc_d = cyc_q + 3'h1;
            end
            if (waits_q != 2'h0) begin
               waits_d = waits_q - 2'h1;
            end else if (cycle_end) begin
               state_d = st_idle;
            end
         end
         default: begin
            state_d = st_idle;
         end
      endcase
      if (!mastership) begin
         state_d = st_idle;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= st_idle;
         waits_q <= 2'h0;
         cyc_q   <= 3'h0;
      end else begin
         state_q <= state_d;
         waits_q <= waits_d;
         cyc_q   <= cyc_d;
      end
   end

   // ----------------------------------------------------------------
   // Ready seen at the T1 edge in synchronous mode
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_t1_q <= 1'b0;
      end else if (state_q == st_t1) begin
         ready_t1_q <= sync_ready_select & ready_raw;
      end else if (state_q == st_idle) begin
         ready_t1_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Cycle status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_t1_q   <= 1'b0;
         dma_t2_q   <= 1'b0;
         done_q     <= 1'b0;
         width_32_q <= 1'b0;
      end else begin
         dma_t1_q   <= (state_d == st_t1);
         dma_t2_q   <= (state_d == st_t2);
         done_q     <= cycle_done;
         width_32_q <= dma_width_select;
      end
   end

   // ----------------------------------------------------------------
   // Completed cycle count, wraps
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_count_q <= 8'h00;
      end else if (cycle_done) begin
         done_count_q <= done_count_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign user_pin_out   = user_pin_out_q;
   assign user_pin_oe    = user_pin_oe_q;
   assign dma_t1         = dma_t1_q;
   assign dma_t2         = dma_t2_q;
   assign dma_cycle_done = done_q;
   assign dma_width_32   = width_32_q;

endmodule

// ### mem_ready_model.sv
// Memory side model that answers DMA cycles on the ready lines.
// Assumes dma_t1 and dma_t2 from the design and a bench latency.

`timescale 1ns/100ps

module mem_ready_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Cycle state and protocol
   input  wire logic       dma_t1,
   input  wire logic       dma_t2,
   input  wire logic       bus_protocol_select,
   input  wire logic [2:0] latency,
   // Ready lines
   output logic            ready_in,
   output logic [1:0]      data_size_acknowledge
);
   logic [2:0] cnt_q;
   logic       rdy_q;

   // Changes only after a rising edge, so the level is stable there
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 3'h0;
         rdy_q <= 1'b0;
      end else begin
         cnt_q <= (dma_t1 | dma_t2) ? cnt_q + 3'h1 : 3'h0;
         rdy_q <= (dma_t1 | dma_t2) && cnt_q >= latency;
      end
   end

   assign ready_in = !bus_protocol_select && rdy_q;
   assign data_size_acknowledge = {2{bus_protocol_select && rdy_q}};
endmodule

// ### dma_bus_cfg_asserts.sv
// Checker for the DMA bus configuration bank, bound to its top module.
// Assumes it sees only top ports; config is shadowed from APB writes.

`timescale 1ns/100ps

module dma_bus_cfg_asserts
   import dma_bus_cfg_pkg::*;
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Bus side
   input wire logic              hold_acknowledge,
   input wire logic              bus_grant_acknowledge,
   input wire logic              bus_protocol_select,
   input wire logic              dma_cycle_req,
   input wire logic              ready_in,
   input wire logic [1:0]        data_size_acknowledge,
   input wire logic [1:0]        user_strap_pins_in,
   input wire logic [1:0]        user_pin_out,
   input wire logic [1:0]        user_pin_oe,
   input wire logic              dma_t1,
   input wire logic              dma_t2,
   input wire logic              dma_cycle_done,
   input wire logic              dma_width_32
);
   // ------------------------------------------------------------
   // Shadow state
   // ------------------------------------------------------------
   logic [CFG_W-1:0] cfg_q;
   logic [1:0]       strap_q;
   logic             cap_q;
   logic [7:0]       t2_cnt_q;
   wire logic        master = hold_acknowledge | bus_grant_acknowledge;
   wire logic        rdy = bus_protocol_select ? |data_size_acknowledge
                                               : ready_in;
   wire logic [1:0]  wcnt = cfg_q[WAIT_COUNT_HI:WAIT_COUNT_LO];
   wire logic [CFG_W-1:0] wmask = CFG_WRITE_MASK &
                                  {{8{pstrb[1]}}, {8{pstrb[0]}}};
   wire logic        cfg_wr = psel & penable & pready & pwrite &
                              (paddr == ADDR_DATA_CONFIG);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q    <= CFG_RESET;
         strap_q  <= 2'b00;
         cap_q    <= 1'b0;
         t2_cnt_q <= 8'h00;
      end else begin
         if (cfg_wr) begin
            cfg_q <= (cfg_q & ~wmask) | (pwdata[CFG_W-1:0] & wmask);
         end
         if (!cap_q) begin
            strap_q <= user_strap_pins_in;
         end
         cap_q    <= 1'b1;
         t2_cnt_q <= dma_t2 ? t2_cnt_q + 8'h01 : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence acc_s;
      psel && penable && !$past(penable);
   endsequence

   sequence cfg_rd_s;
      psel && pready && !pwrite && !pslverr && paddr == ADDR_DATA_CONFIG;
   endsequence

   apb_one_wait_a: assert property (acc_s |-> !pready ##1 pready)
      else $error("APB answer not after one wait");
   strap_hold_a: assert property (
      cfg_rd_s |-> prdata[USER_STRAP_HI:USER_STRAP_LO] == strap_q)
      else $error("strap bits differ from captured levels");
   pin_enable_a: assert property (
      1'b1 |=> user_pin_oe == {2{$past(master)}})
      else $error("user pin enable not following mastership");
   pin_level_a: assert property (
      $changed(cfg_q[12:11]) |-> ##[0:2] user_pin_out == cfg_q[12:11])
      else $error("user pin level not following drive bits");
   no_master_a: assert property (
      !master |=> !dma_t1 && !dma_t2)
      else $error("DMA state held without mastership");
   sync_ready_a: assert property (
      dma_t2 && master && rdy && cfg_q[SYNC_READY_BIT] &&
      t2_cnt_q >= {6'h00, wcnt} |=> !dma_t2)
      else $error("synchronous ready not taken at once");
   async_sync_a: assert property (
      dma_t2 && master && !cfg_q[SYNC_READY_BIT] && $rose(rdy) |=> dma_t2)
      else $error("asynchronous ready bypassed synchroniser");
   wait_len_a: assert property (
      dma_cycle_done |-> t2_cnt_q >= {6'h00, wcnt} + 8'h01)
      else $error("too few T2 states");
   async_len_a: assert property (
      dma_cycle_done && !cfg_q[SYNC_READY_BIT] |-> t2_cnt_q >= 8'h02)
      else $error("asynchronous cycle under three clocks");
endmodule

bind dma_bus_config_fields dma_bus_cfg_asserts dma_bus_cfg_asserts_inst (
   .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .hold_acknowledge, .bus_grant_acknowledge,
   .bus_protocol_select, .dma_cycle_req, .ready_in, .data_size_acknowledge,
   .user_strap_pins_in, .user_pin_out, .user_pin_oe, .dma_t1, .dma_t2,
   .dma_cycle_done, .dma_width_32
);

// ### tb.sv
// Self-checking bench for the DMA bus configuration bank.
// Assumes the memory ready model and the bound checker.

`timescale 1ns/100ps

module tb
   import dma_bus_cfg_pkg::*;
;
   localparam logic [DATA_W-1:0] ZERO = 32'h0000_0000;
   logic              pclk, presetn, psel, penable, pwrite, pready;
   logic              pslverr, hold_acknowledge, bus_grant_acknowledge;
   logic              bus_protocol_select, dma_cycle_req, ready_in, err;
   logic              dma_t1, dma_t2, dma_cycle_done, dma_width_32;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [3:0]        pstrb;
   logic [2:0]        latency;
   logic [1:0]        data_size_acknowledge, user_strap_pins_in;
   logic [1:0]        user_pin_out, user_pin_oe;
   int                errors, comparisons, cycles, t2n, lo;

   dma_bus_config_fields dma_bus_config_fields_inst (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .hold_acknowledge, .bus_grant_acknowledge,
      .bus_protocol_select, .dma_cycle_req, .ready_in,
      .data_size_acknowledge, .user_strap_pins_in, .user_pin_out,
      .user_pin_oe, .dma_t1, .dma_t2, .dma_cycle_done, .dma_width_32);
   mem_ready_model mem_ready_model_inst (
      .pclk, .presetn, .dma_t1, .dma_t2, .bus_protocol_select, .latency,
      .ready_in, .data_size_acknowledge);

   // ------------------------------------------------------------
   // Clock, timeout and tasks
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic dma();
      t2n = 0;
      @(posedge pclk);
      dma_cycle_req <= 1'b1;
      repeat (40) begin
         @(posedge pclk);
         dma_cycle_req <= 1'b0;
         if (dma_t2 === 1'b1) t2n++;
         if (dma_cycle_done === 1'b1) break;
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      paddr = 12'h000;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = ZERO;
      pstrb = 4'hF;
      hold_acknowledge = 1'b0;
      bus_grant_acknowledge = 1'b0;
      bus_protocol_select = 1'b0;
      dma_cycle_req = 1'b0;
      latency = 3'h0;
      user_strap_pins_in = 2'b10;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_DATA_CONFIG, ZERO);
      chk(rd, 32'h0000_0200);
      user_strap_pins_in <= 2'b01;
      apb(1'b1, ADDR_DATA_CONFIG, 32'hFFFF_FFFF);
      apb(1'b0, ADDR_DATA_CONFIG, ZERO);
      chk(rd, 32'h0000_1EE0);
      chk({31'h0, dma_width_32}, 32'h0000_0001);
      chk({30'h0, user_pin_oe}, ZERO);
      apb(1'b0, 12'hFF0, ZERO);
      chk({31'h0, err}, 32'h0000_0001);
      chk(rd, ZERO);
      apb(1'b1, ADDR_DATA_CONFIG, 32'h0000_0800);
      hold_acknowledge <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({28'h0, user_pin_oe, user_pin_out}, 32'h0000_000D);
      hold_acknowledge <= 1'b0;
      bus_grant_acknowledge <= 1'b1;
      apb(1'b1, ADDR_DATA_CONFIG, 32'h0000_1000);
      repeat (2) @(posedge pclk);
      chk({28'h0, user_pin_oe, user_pin_out}, 32'h0000_000E);
      chk({31'h0, dma_width_32}, ZERO);
      for (int m = 0; m < 16; m++) begin
         bus_protocol_select <= m[3];
         latency <= 3'(m % 3);
         apb(1'b1, ADDR_DATA_CONFIG, {21'h0, m[2], 2'h0, m[1:0], 6'h00});
         dma();
         lo = (m[1:0] > m % 3) ? m[1:0] + 1 : m % 3 + 1;
         if (m[2]) begin
            chk(t2n, lo);
         end else begin
            chk(t2n >= (lo > 2 ? lo : 2) && t2n <= lo + 3, 1);
         end
      end
      latency <= 3'h7;
      dma_cycle_req <= 1'b1;
      repeat (3) @(posedge pclk);
      bus_grant_acknowledge <= 1'b0;
      dma_cycle_req <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({30'h0, dma_t1, dma_t2}, ZERO);
      bus_grant_acknowledge <= 1'b1;
      apb(1'b0, ADDR_CYCLE_STATUS, ZERO);
      chk(rd, 32'h0000_1004);
      bus_grant_acknowledge <= 1'b0;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_DATA_CONFIG, ZERO);
      chk(rd, 32'h0000_0100);
      summarize();
   end
endmodule
